// *** src/dual_launch_pkg.sv ***
// Constants for the dual-joint launch command handler.
// Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
package dual_launch_pkg;
  localparam int unsigned OP_W = 16;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] MODSEL_OFS   = 8'h04;
  localparam logic [7:0] JSEL_OFS     = 8'h08;
  localparam logic [7:0] XSTEP_OFS    = 8'h0c;
  localparam logic [7:0] YSTEP_OFS    = 8'h10;
  localparam logic [7:0] ZSTEP_OFS    = 8'h14;
  localparam logic [7:0] MASK_OFS     = 8'h18;
  localparam logic [7:0] STATUS_OFS   = 8'h1c;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h20;
  localparam logic [7:0] IRQ_CLR_OFS  = 8'h24;
  localparam logic [7:0] IRQ_EN_OFS   = 8'h28;

  // CTRL fields
  localparam int unsigned CTRL_COND_BIT = 0;
  localparam int unsigned CTRL_ADV_BIT  = 1;

  // STATUS fields
  localparam int unsigned ST_INSTR_FAULT_BIT = 0;
  localparam int unsigned ST_X_FAULT_BIT     = 1;
  localparam int unsigned ST_Y_FAULT_BIT     = 2;
  localparam int unsigned ST_X_MOVING_BIT    = 3;
  localparam int unsigned ST_Y_MOVING_BIT    = 4;
  localparam int unsigned ST_ERR_CODE_LSB    = 16;

  // Interrupt event bits
  localparam int unsigned EV_LAUNCH_BIT      = 0;
  localparam int unsigned EV_INSTR_FAULT_BIT = 1;
  localparam int unsigned EV_JOINT_FAULT_BIT = 2;
  localparam int unsigned EV_MASK_ERR_BIT    = 3;
  localparam int unsigned EV_W               = 4;

  // Operand limits and codes
  localparam logic [OP_W-1:0] STEP_MAX_STD   = 16'h001e;
  localparam logic [OP_W-1:0] STEP_MAX_ADV   = 16'h0050;
  localparam logic [OP_W-1:0] MASK_REQUIRED  = 16'h0003;
  localparam logic [OP_W-1:0] MODSEL_BUILTIN = 16'h0000;
  localparam logic [OP_W-1:0] JSEL_MAX       = 16'h0001;
  localparam logic [OP_W-1:0] ERR_MASK       = 16'h0128;
  localparam logic [OP_W-1:0] ERR_NONE       = 16'h0000;

  // Reset values
  localparam logic [31:0]     CTRL_RST = 32'h0000_0000;
  localparam logic [OP_W-1:0] OP_RST   = 16'h0000;
  localparam logic [EV_W-1:0] EV_RST   = 4'h0;
endpackage

// *** src/launch_check_if.sv ***
// Operand bundle and verdicts between the launch handler and its checker.
// Both ends run on the same clock; the checker is purely combinational.
`timescale 1ns/1ps
`default_nettype none
interface launch_check_if;
  logic [dual_launch_pkg::OP_W-1:0] module_position_select;
  logic [dual_launch_pkg::OP_W-1:0] command_joint_select;
  logic [dual_launch_pkg::OP_W-1:0] x_joint_step_index;
  logic [dual_launch_pkg::OP_W-1:0] y_joint_step_index;
  logic [dual_launch_pkg::OP_W-1:0] joint_enable_mask;
  logic                             advanced_mode;
  logic                             instr_bad;
  logic                             x_step_bad;
  logic                             y_step_bad;
  logic                             mask_bad;

  modport handler (
    output module_position_select, command_joint_select, x_joint_step_index,
    output y_joint_step_index, joint_enable_mask, advanced_mode,
    input  instr_bad, x_step_bad, y_step_bad, mask_bad
  );
  modport checker_end (
    input  module_position_select, command_joint_select, x_joint_step_index,
    input  y_joint_step_index, joint_enable_mask, advanced_mode,
    output instr_bad, x_step_bad, y_step_bad, mask_bad
  );
endinterface
`default_nettype wire

// *** src/launch_operand_check.sv ***
// Combinational operand checks for the dual-joint launch command.
// Assumes operands are stable registers in the handler's clock domain.
`timescale 1ns/1ps
`default_nettype none
module launch_operand_check (
  // Operands in, verdicts out
  launch_check_if.checker_end chk
);
  function automatic logic step_out_of_range(input logic [dual_launch_pkg::OP_W-1:0] step,
                                             input logic                             adv);
    logic [dual_launch_pkg::OP_W-1:0] lim;
    lim = adv ? dual_launch_pkg::STEP_MAX_ADV : dual_launch_pkg::STEP_MAX_STD;
    return step > lim;
  endfunction

  // Only the built-in positioning target is served
  assign chk.instr_bad  = (chk.command_joint_select > dual_launch_pkg::JSEL_MAX) ||
                          (chk.module_position_select != dual_launch_pkg::MODSEL_BUILTIN);
  assign chk.x_step_bad = step_out_of_range(chk.x_joint_step_index, chk.advanced_mode);
  assign chk.y_step_bad = step_out_of_range(chk.y_joint_step_index, chk.advanced_mode);
  // All 16 bits compared: bit 0 X, bit 1 Y, the rest must be clear
  assign chk.mask_bad   = chk.joint_enable_mask != dual_launch_pkg::MASK_REQUIRED;
endmodule
`default_nettype wire

// *** src/dual_joint_launch.sv ***
// Dual-joint launch command handler with an AHB-Lite register slave.
// Assumes the motion engine reports end of motion per axis on this clock.
//
// Notes on behaviour
// - Launch only on rising edge of condition.
// - X uses x step, Y uses y step.
// - Bad step: joint fault, no motion.
// - Third-axis step operand is ignored entirely.
// - Mask bit0 X, bit1 Y, others must be clear.
// - Mask must equal 3, else code 296.
// - Bad joint select sets instruction fault flag.
// - Bad joint select leaves joint faults clear.
// - Valid joint select does not affect motion.
// - Module select must be 0 (built-in).
// - Readable moving and fault bits per axis.
`timescale 1ns/1ps
`default_nettype none
module dual_joint_launch (
  // Clock and reset
  input  wire logic                             hclk,
  input  wire logic                             hresetn,
  // AHB-Lite slave
  input  wire logic                             hsel,
  input  wire logic [31:0]                      haddr,
  input  wire logic [1:0]                       htrans,
  input  wire logic                             hwrite,
  input  wire logic [2:0]                       hsize,
  input  wire logic [31:0]                      hwdata,
  input  wire logic                             hready,
  output logic                                  hreadyout,
  output logic                                  hresp,
  output logic [31:0]                           hrdata,
  // Motion engine
  output logic                                  x_launch,
  output logic                                  y_launch,
  output logic [dual_launch_pkg::OP_W-1:0]      x_launch_step,
  output logic [dual_launch_pkg::OP_W-1:0]      y_launch_step,
  input  wire logic                             x_motion_done,
  input  wire logic                             y_motion_done,
  // Status
  output logic                                  x_joint_moving,
  output logic                                  y_joint_moving,
  output logic                                  x_joint_fault,
  output logic                                  y_joint_fault,
  output logic                                  instr_fault_flag,
  output logic                                  irq
);
  localparam int unsigned W = dual_launch_pkg::OP_W;

  typedef struct packed {
    logic            dp_write;
    logic [7:0]      dp_addr;
    logic [31:0]     rdata;
    logic            cond;
    logic            cond_prev;
    logic            adv;
    logic [W-1:0]    modsel;
    logic [W-1:0]    jsel;
    logic [W-1:0]    xstep;
    logic [W-1:0]    ystep;
    logic [W-1:0]    zstep;
    logic [W-1:0]    mask;
    logic [W-1:0]    err_code;
    logic            instr_fault;
    logic            x_fault;
    logic            y_fault;
    logic            x_moving;
    logic            y_moving;
    logic            x_go;
    logic            y_go;
    logic [W-1:0]    x_go_step;
    logic [W-1:0]    y_go_step;
    logic [dual_launch_pkg::EV_W-1:0] ev_stat;
    logic [dual_launch_pkg::EV_W-1:0] ev_en;
  } state_s;

  state_s st_q;
  state_s st_d;

  launch_check_if chk_if ();

  launch_operand_check u_check (
    .chk (chk_if.checker_end)
  );

  // Third-axis step is held for readback only and never reaches the checker
  assign chk_if.module_position_select = st_q.modsel;
  assign chk_if.command_joint_select   = st_q.jsel;
  assign chk_if.x_joint_step_index     = st_q.xstep;
  assign chk_if.y_joint_step_index     = st_q.ystep;
  assign chk_if.joint_enable_mask      = st_q.mask;
  assign chk_if.advanced_mode          = st_q.adv;

  function automatic logic [31:0] read_word(input state_s s, input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    unique case (a)
      dual_launch_pkg::CTRL_OFS: begin
        r[dual_launch_pkg::CTRL_COND_BIT] = s.cond;
        r[dual_launch_pkg::CTRL_ADV_BIT]  = s.adv;
      end
      dual_launch_pkg::MODSEL_OFS: r[W-1:0] = s.modsel;
      dual_launch_pkg::JSEL_OFS:   r[W-1:0] = s.jsel;
      dual_launch_pkg::XSTEP_OFS:  r[W-1:0] = s.xstep;
      dual_launch_pkg::YSTEP_OFS:  r[W-1:0] = s.ystep;
      dual_launch_pkg::ZSTEP_OFS:  r[W-1:0] = s.zstep;
      dual_launch_pkg::MASK_OFS:   r[W-1:0] = s.mask;
      dual_launch_pkg::STATUS_OFS: begin
        r[dual_launch_pkg::ST_INSTR_FAULT_BIT] = s.instr_fault;
        r[dual_launch_pkg::ST_X_FAULT_BIT]     = s.x_fault;
        r[dual_launch_pkg::ST_Y_FAULT_BIT]     = s.y_fault;
        r[dual_launch_pkg::ST_X_MOVING_BIT]    = s.x_moving;
        r[dual_launch_pkg::ST_Y_MOVING_BIT]    = s.y_moving;
        r[dual_launch_pkg::ST_ERR_CODE_LSB +: W] = s.err_code;
      end
      dual_launch_pkg::IRQ_STAT_OFS: r[dual_launch_pkg::EV_W-1:0] = s.ev_stat;
      dual_launch_pkg::IRQ_EN_OFS:   r[dual_launch_pkg::EV_W-1:0] = s.ev_en;
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  logic                             addr_phase;
  logic                             edge_seen;
  logic [dual_launch_pkg::EV_W-1:0] ev_set;
  logic [dual_launch_pkg::EV_W-1:0] ev_clr;

  assign addr_phase = hsel && htrans[1] && hready;

  always_comb begin
    st_d      = st_q;
    ev_set    = dual_launch_pkg::EV_RST;
    ev_clr    = dual_launch_pkg::EV_RST;
    st_d.x_go = 1'b0;
    st_d.y_go = 1'b0;

    // Data phase of a write: registers load from hwdata
    if (st_q.dp_write) begin
      unique case (st_q.dp_addr)
        dual_launch_pkg::CTRL_OFS: begin
          st_d.cond = hwdata[dual_launch_pkg::CTRL_COND_BIT];
          st_d.adv  = hwdata[dual_launch_pkg::CTRL_ADV_BIT];
        end
        dual_launch_pkg::MODSEL_OFS:  st_d.modsel = hwdata[W-1:0];
        dual_launch_pkg::JSEL_OFS:    st_d.jsel   = hwdata[W-1:0];
        dual_launch_pkg::XSTEP_OFS:   st_d.xstep  = hwdata[W-1:0];
        dual_launch_pkg::YSTEP_OFS:   st_d.ystep  = hwdata[W-1:0];
        dual_launch_pkg::ZSTEP_OFS:   st_d.zstep  = hwdata[W-1:0];
        dual_launch_pkg::MASK_OFS:    st_d.mask   = hwdata[W-1:0];
        dual_launch_pkg::IRQ_CLR_OFS: ev_clr = hwdata[dual_launch_pkg::EV_W-1:0];
        dual_launch_pkg::IRQ_EN_OFS:  st_d.ev_en = hwdata[dual_launch_pkg::EV_W-1:0];
        default: ;
      endcase
    end

    st_d.dp_write = addr_phase && hwrite;
    st_d.dp_addr  = {haddr[7:2], 2'b00};
    // Read data is registered at the address phase so hrdata comes from a flop
    if (addr_phase && !hwrite) begin
      st_d.rdata = read_word(st_q, {haddr[7:2], 2'b00});
    end

    // The engine's done pulse ends motion of that axis
    if (x_motion_done) begin
      st_d.x_moving = 1'b0;
    end
    if (y_motion_done) begin
      st_d.y_moving = 1'b0;
    end

    // A held condition is seen once; only the low-to-high change launches
    st_d.cond_prev = st_q.cond;
    edge_seen      = st_q.cond && !st_q.cond_prev;
    if (edge_seen) begin
      // Each evaluation reports afresh, so old faults are dropped here
      st_d.instr_fault = 1'b0;
      st_d.x_fault     = 1'b0;
      st_d.y_fault     = 1'b0;
      st_d.err_code    = dual_launch_pkg::ERR_NONE;
      if (chk_if.instr_bad) begin
        // Discarded; joint faults stay clear
        st_d.instr_fault = 1'b1;
        ev_set[dual_launch_pkg::EV_INSTR_FAULT_BIT] = 1'b1;
      end else if (chk_if.x_step_bad || chk_if.y_step_bad) begin
        st_d.x_fault = chk_if.x_step_bad;
        st_d.y_fault = chk_if.y_step_bad;
        ev_set[dual_launch_pkg::EV_JOINT_FAULT_BIT] = 1'b1;
      end else if (chk_if.mask_bad) begin
        st_d.err_code = dual_launch_pkg::ERR_MASK;
        ev_set[dual_launch_pkg::EV_MASK_ERR_BIT] = 1'b1;
      end else begin
        // Joint select value plays no part past this point
        st_d.x_go      = 1'b1;
        st_d.y_go      = 1'b1;
        st_d.x_go_step = st_q.xstep;
        st_d.y_go_step = st_q.ystep;
        st_d.x_moving  = 1'b1;
        st_d.y_moving  = 1'b1;
        ev_set[dual_launch_pkg::EV_LAUNCH_BIT] = 1'b1;
      end
    end

    // New events win over a clear in the same cycle
    st_d.ev_stat = (st_q.ev_stat & ~ev_clr) | ev_set;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign hreadyout        = 1'b1;
  assign hresp            = 1'b0;
  assign hrdata           = st_q.rdata;
  assign x_launch         = st_q.x_go;
  assign y_launch         = st_q.y_go;
  assign x_launch_step    = st_q.x_go_step;
  assign y_launch_step    = st_q.y_go_step;
  assign x_joint_moving   = st_q.x_moving;
  assign y_joint_moving   = st_q.y_moving;
  assign x_joint_fault    = st_q.x_fault;
  assign y_joint_fault    = st_q.y_fault;
  assign instr_fault_flag = st_q.instr_fault;
  assign irq              = |(st_q.ev_stat & st_q.ev_en);
endmodule
`default_nettype wire

// *** dv/motion_engine_model.sv ***
// Behavioural motion engine that ends a move a set number of cycles after launch.
// Assumes launch is a one-cycle pulse on the handler's clock.
`timescale 1ns/1ps
`default_nettype none
module motion_engine_model #(
  parameter int DLY = 6
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Launch in, completion out
  input  wire logic start,
  output logic      done
);
  int cnt_q;
  // A relaunch mid-move restarts the count, as a fresh move would
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 0;
      done  <= 1'b0;
    end else begin
      done  <= (cnt_q == 1);
      cnt_q <= start ? DLY : (cnt_q > 0 ? cnt_q - 1 : 0);
    end
  end
endmodule
`default_nettype wire

// *** dv/launch_rules_checker.sv ***
// Port-level checks for the dual-joint launch handler.
// Assumes it is bound onto the handler and sees its ports by name.
`timescale 1ns/1ps
`default_nettype none
module launch_rules_checker (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Motion engine side
  input wire logic        x_launch,
  input wire logic        y_launch,
  input wire logic [15:0] x_launch_step,
  input wire logic [15:0] y_launch_step,
  input wire logic        x_motion_done,
  // Status
  input wire logic        x_joint_moving,
  input wire logic        y_joint_moving,
  input wire logic        x_joint_fault,
  input wire logic        y_joint_fault,
  input wire logic        instr_fault_flag,
  input wire logic        irq
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  launch_pair_a: assert property (x_launch == y_launch)
    else $error("axes launched apart");
  launch_pulse_a: assert property (x_launch |=> !x_launch)
    else $error("launch pulse too long");
  launch_moving_a: assert property (x_launch |-> x_joint_moving && y_joint_moving)
    else $error("moving not set with launch");
  moving_cause_a: assert property ($rose(y_joint_moving) |-> y_launch)
    else $error("moving rose without launch");
  launch_clean_a: assert property (x_launch |-> !(x_joint_fault || y_joint_fault))
    else $error("launch with joint fault");
  instr_excl_a: assert property (instr_fault_flag |-> !x_joint_fault && !y_joint_fault)
    else $error("joint fault beside instruction fault");
  fault_hold_a: assert property ($rose(instr_fault_flag) |-> !x_launch)
    else $error("launch despite instruction fault");
  // A fresh launch in the done cycle legally sets moving again
  done_clear_a: assert property (x_joint_moving && x_motion_done && !x_launch
                                 |=> !x_joint_moving || x_launch)
    else $error("moving not cleared after done");
  step_hold_a: assert property (!x_launch |-> $stable(x_launch_step) && $stable(y_launch_step))
    else $error("step changed without launch");
  cover property (x_launch);
  cover property ($rose(instr_fault_flag));
  cover property ($rose(y_joint_fault));
  cover property ($rose(irq));
endmodule
`default_nettype wire

// *** dv/tb_dual_joint_launch.sv ***
// Self-checking bench for the dual-joint launch handler over AHB-Lite.
// Assumes a zero-wait slave; two engine models end moves at different speeds.
`timescale 1ns/1ps
`default_nettype none
module tb_dual_joint_launch;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic        x_launch, y_launch, irq, x_motion_done, y_motion_done;
  logic [15:0] x_launch_step, y_launch_step;
  logic        x_joint_moving, y_joint_moving, x_joint_fault, y_joint_fault;
  logic        instr_fault_flag;
  int          error_cnt, checks_done;
  logic [15:0] masks [5] = '{16'h0000, 16'h0001, 16'h0002, 16'h0007, 16'h8003};
  logic [7:0]  ofs [6] = '{8'h00, 8'h1c, 8'h20, 8'h24, 8'h28, 8'h3c};
  assign hready = hreadyout;
  dual_joint_launch dual_joint_launch_i (
    .hclk             (hclk),
    .hresetn          (hresetn),
    .hsel             (hsel),
    .haddr            (haddr),
    .htrans           (htrans),
    .hwrite           (hwrite),
    .hsize            (3'b010),
    .hwdata           (hwdata),
    .hready           (hready),
    .hreadyout        (hreadyout),
    .hresp            (hresp),
    .hrdata           (hrdata),
    .x_launch         (x_launch),
    .y_launch         (y_launch),
    .x_launch_step    (x_launch_step),
    .y_launch_step    (y_launch_step),
    .x_motion_done    (x_motion_done),
    .y_motion_done    (y_motion_done),
    .x_joint_moving   (x_joint_moving),
    .y_joint_moving   (y_joint_moving),
    .x_joint_fault    (x_joint_fault),
    .y_joint_fault    (y_joint_fault),
    .instr_fault_flag (instr_fault_flag),
    .irq              (irq)
  );
  motion_engine_model #(.DLY(6)) x_engine_i (.clk(hclk), .rst_n(hresetn), .start(x_launch),
                                             .done(x_motion_done));
  motion_engine_model #(.DLY(12)) y_engine_i (.clk(hclk), .rst_n(hresetn), .start(y_launch),
                                              .done(y_motion_done));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_ready();
    int n;
    for (n = 0; n < 16; n++) begin
      @(posedge hclk);
      if (hready === 1'b1) break;
    end
    if (n == 16) begin
      error_cnt++;
      report_and_stop();
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= {24'h0, a};
    wait_ready();
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
  endtask
  // Operands go in order modsel, jsel, x, y, z, mask; then cond is toggled 0 then 1
  task automatic run(input logic [15:0] ms, js, xs, ys, zs, mk, input logic adv, go,
                     input logic [31:0] st);
    logic [15:0] v [6];
    v = '{ms, js, xs, ys, zs, mk};
    repeat (30) @(posedge hclk);
    for (int i = 0; i < 6; i++) ahb(1'b1, 8'(4 * (i + 1)), {16'h0, v[i]});
    ahb(1'b1, 8'h00, {30'h0, adv, 1'b0});
    ahb(1'b1, 8'h00, {30'h0, adv, 1'b1});
    // The verdict is registered one edge after cond lands
    @(posedge hclk);
    #1;
    check({30'h0, x_launch, y_launch}, {30'h0, go, go});
    if (go) check({x_launch_step, y_launch_step}, {xs, ys});
    check({27'h0, y_joint_moving, x_joint_moving, y_joint_fault, x_joint_fault,
           instr_fault_flag}, {27'h0, st[4:0]});
    ahb(1'b0, 8'h1c, 32'h0);
    check(rd, st);
  endtask
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  initial begin
    repeat (100000) @(posedge hclk);
    error_cnt++;
    report_and_stop();
  end
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    error_cnt = 0;
    checks_done = 0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b1, 8'h3c, 32'hffff_ffff);
    foreach (ofs[i]) begin
      ahb(1'b0, ofs[i], 32'h0);
      check(rd, 32'h0);
    end
    $display("test reset done");
    run(0, 1, 30, 0, 16'hbeef, 3, 0, 1, 32'h18);
    ahb(1'b1, 8'h00, 32'h1);
    repeat (4) begin
      @(posedge hclk);
      #1;
      check({31'h0, x_launch}, 32'h0);
    end
    $display("test launch done");
    run(0, 0, 31, 30, 0, 3, 0, 0, 32'h2);
    run(0, 0, 80, 81, 0, 3, 1, 0, 32'h4);
    run(0, 0, 80, 80, 0, 3, 1, 1, 32'h18);
    $display("test steps done");
    foreach (masks[i]) run(0, 0, 1, 2, 0, masks[i], 0, 0, {16'd296, 16'h0});
    $display("test mask done");
    run(0, 2, 31, 0, 0, 3, 0, 0, 32'h1);
    run(1, 0, 1, 2, 0, 3, 0, 0, 32'h1);
    $display("test select done");
    ahb(1'b0, 8'h20, 32'h0);
    check(rd, 32'hf);
    check({31'h0, irq}, 32'h0);
    ahb(1'b1, 8'h28, 32'h2);
    #1;
    check({31'h0, irq}, 32'h1);
    ahb(1'b1, 8'h24, 32'h2);
    #1;
    check({31'h0, irq}, 32'h0);
    ahb(1'b0, 8'h20, 32'h0);
    check(rd, 32'hd);
    $display("test irq done");
    report_and_stop();
  end
endmodule
bind dual_joint_launch launch_rules_checker launch_rules_checker_i (
  .hclk             (hclk),
  .hresetn          (hresetn),
  .x_launch         (x_launch),
  .y_launch         (y_launch),
  .x_launch_step    (x_launch_step),
  .y_launch_step    (y_launch_step),
  .x_motion_done    (x_motion_done),
  .x_joint_moving   (x_joint_moving),
  .y_joint_moving   (y_joint_moving),
  .x_joint_fault    (x_joint_fault),
  .y_joint_fault    (y_joint_fault),
  .instr_fault_flag (instr_fault_flag),
  .irq              (irq)
);
`default_nettype wire
